// >>> design/sensor_event_flags_and_results.sv
/*
 * Event flags, interrupt output, response register and the first three
 * result bytes of the sensor register map.
 * Assumes the register port and sequencer strobes are synchronous to clock,
 * and that the enable mask and condition fields come from registers elsewhere.
 * Assumes the host never reads and writes in one cycle; if it does, the read
 * returns the value from before the write.
 * Assumes each converter overflow arrives as a single-cycle pulse.
 * Assumes the proximity conditions change only between measurements.
 */
`timescale 1ns/1ps
module sensor_event_flags_and_results
	import sensor_flags_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire reg_req_t   host_req,
	output logic      [7:0] host_rdata,
	input  wire seq_event_t seq_evt,
	input  wire result_wr_t seq_res,
	input  wire overflow_t  adc_ovf,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_is_clear,
	output logic            cmd_accept,
	input  wire logic       int_mode,
	input  wire logic [5:0] irq_enable,
	input  wire logic [1:0] proximity_event_condition_one,
	input  wire logic [1:0] proximity_event_condition_two,
	input  wire logic [1:0] proximity_event_condition_three,
	output logic            int_out,
	output logic      [7:0] response,
	output logic      [7:0] status
);

	// Address decode; the response register is read-only from the port,
	// so a host write to its offset is dropped rather than decoded
	logic sel_response;
	logic sel_status;
	logic sel_vis_low;
	logic sel_vis_high;
	logic sel_ir_low;
	logic wr_status;

	assign sel_response = (host_req.addr == response_off);
	assign sel_status   = (host_req.addr == status_off);
	assign sel_vis_low  = (host_req.addr == vis_low_off);
	assign sel_vis_high = (host_req.addr == vis_high_off);
	assign sel_ir_low   = (host_req.addr == ir_low_off);
	assign wr_status    = host_req.wr & sel_status;

	// Host clear mask: only ones in defined bits clear, reserved bits dropped
	// Writing zero to a flag bit leaves it alone
	logic [7:0] host_clr_mask;

	assign host_clr_mask = wr_status ? (host_req.wdata & status_wmask) : 8'h00;

	// Sequencer clear only in automatic mode. Mode 0 leaves every flag to
	// the host, the safer choice: an event raised just before an automatic
	// clear would otherwise vanish unseen. A proximity channel in
	// condition 11 stays with the host even in mode 1.
	logic auto_clr;
	logic keep_one;
	logic keep_two;
	logic keep_three;

	assign auto_clr   = int_mode & seq_evt.auto_clear;
	assign keep_one   = (proximity_event_condition_one == cond_no_autoclr);
	assign keep_two   = (proximity_event_condition_two == cond_no_autoclr);
	assign keep_three = (proximity_event_condition_three == cond_no_autoclr);

	// Per-channel sequencer clear strobes
	// Kept as named wires so each exemption is easy to follow
	logic clr_one;
	logic clr_two;
	logic clr_three;

	assign clr_one   = auto_clr & ~keep_one;
	assign clr_two   = auto_clr & ~keep_two;
	assign clr_three = auto_clr & ~keep_three;

	// Flag bits
	// Each flag is one small module, so set-beats-clear is written once
	logic       cmd_flag;
	logic       proximity_one_flag;
	logic       proximity_two_flag;
	logic       proximity_three_flag;
	logic [1:0] ambient_event_field;

	// Command completion flag
	sticky_flag #(
		.w (1)
	) u_cmd_flag (
		.clock    (clock),
		.nrst     (nrst),
		.set_val  (seq_evt.cmd_done),
		.host_clr (host_clr_mask[cmd_bit]),
		.seq_clr  (auto_clr),
		.flag     (cmd_flag)
	);

	// Proximity channels; each clear strobe already honours its condition
	// Proximity channel one
	sticky_flag #(
		.w (1)
	) u_prox_one (
		.clock    (clock),
		.nrst     (nrst),
		.set_val  (seq_evt.prox_set[0]),
		.host_clr (host_clr_mask[prox_one_bit]),
		.seq_clr  (clr_one),
		.flag     (proximity_one_flag)
	);

	// Proximity channel two
	sticky_flag #(
		.w (1)
	) u_prox_two (
		.clock    (clock),
		.nrst     (nrst),
		.set_val  (seq_evt.prox_set[1]),
		.host_clr (host_clr_mask[prox_two_bit]),
		.seq_clr  (clr_two),
		.flag     (proximity_two_flag)
	);

	// Proximity channel three
	sticky_flag #(
		.w (1)
	) u_prox_three (
		.clock    (clock),
		.nrst     (nrst),
		.set_val  (seq_evt.prox_set[2]),
		.host_clr (host_clr_mask[prox_three_bit]),
		.seq_clr  (clr_three),
		.flag     (proximity_three_flag)
	);

	// Ambient field keeps the code last reported until cleared
	// A new code replaces the old one outright; merging bits would invent codes
	sticky_flag #(
		.w (amb_width)
	) u_amb (
		.clock    (clock),
		.nrst     (nrst),
		.set_val  (seq_evt.amb_set),
		.host_clr (host_clr_mask[amb_lsb +: amb_width]),
		.seq_clr  (auto_clr),
		.flag     (ambient_event_field)
	);

	// Status assembly, reserved bits read zero
	// and ignore writes, since the clear mask drops them
	logic [7:0] status_w;

	assign status_w = {2'b00, cmd_flag, proximity_three_flag, proximity_two_flag,
			proximity_one_flag, ambient_event_field};
	assign status   = status_w;

	// Pending events per bit position; any ambient code counts as one
	// Bit 1 has no event of its own: the ambient field is a single event
	logic [5:0] pending;

	assign pending = {cmd_flag, proximity_three_flag, proximity_two_flag,
			proximity_one_flag, 1'b0, |ambient_event_field};

	// Interrupt output from a flop so the pin never glitches
	// The price is one clock of latency after a flag changes
	logic int_r;
	logic int_nxt;

	assign int_nxt = |(pending & irq_enable);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			int_r <= 1'b0;
		end else begin
			int_r <= int_nxt;
		end
	end

	assign int_out = int_r;

	// Response register: error codes stick until a clearing command.
	// Outside an error, bits 3:0 count executed commands and roll over,
	// so the host can confirm a command ran when its timing is not fixed.
	logic [7:0] response_r;
	logic [7:0] response_nxt;
	logic       err_held;
	logic [7:0] ovf_code;
	logic       ovf_any;
	logic       ovf_load;
	logic       clr_cmd;
	logic       cmd_inc;
	logic [7:0] resp_count;

	assign err_held = response_r[err_flag_bit];
	assign ovf_any  = adc_ovf.prox3 | adc_ovf.vis | adc_ovf.aux;

	// Named terms for the next-value logic; a held error blocks both loads
	assign ovf_load   = ovf_any & ~err_held;
	assign clr_cmd    = cmd_valid & cmd_is_clear;
	assign cmd_inc    = seq_evt.cmd_done & ~err_held;
	assign resp_count = {4'h0, response_r[3:0] + 4'h1};

	// Fixed priority when several converters overflow together:
	// third proximity channel first, then visible light, then auxiliary
	assign ovf_code = adc_ovf.prox3 ? err_ovf_prox3 :
			(adc_ovf.vis ? err_ovf_vis : err_ovf_aux);

	// Commands other than the clearing ones are refused while an error stands
	// Autonomous measurements go on; only commands are refused
	assign cmd_accept = cmd_valid & (~err_held | cmd_is_clear);

	// Overflow beats clear when no error is held, so a same-cycle first error is not lost;
	// an increment never touches an error code
	always_comb begin
		response_nxt = response_r;
		if (ovf_load) begin
			response_nxt = ovf_code;
		end else if (clr_cmd) begin
			response_nxt = response_rst;
		end else if (cmd_inc) begin
			response_nxt = resp_count;
		end
	end

	// Response flop; reset leaves the counter at zero
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			response_r <= response_rst;
		end else begin
			response_r <= response_nxt;
		end
	end

	assign response = response_r;

	// Result bytes; the host must read them before the next overwrite.
	// Both visible bytes load on one strobe, so a word never mixes two runs.
	logic [7:0] vis_low;
	logic [7:0] vis_high;
	logic [7:0] ir_low;
	logic       wr_vis_low;
	logic       wr_vis_high;
	logic       wr_ir_low;

	assign wr_vis_low  = host_req.wr & sel_vis_low;
	assign wr_vis_high = host_req.wr & sel_vis_high;
	assign wr_ir_low   = host_req.wr & sel_ir_low;

	// Visible word, low byte
	result_byte u_vis_low (
		.clock     (clock),
		.nrst      (nrst),
		.seq_we    (seq_res.vis_we),
		.seq_data  (seq_res.vis_data[7:0]),
		.host_we   (wr_vis_low),
		.host_data (host_req.wdata),
		.value     (vis_low)
	);

	// Visible word, high byte
	result_byte u_vis_high (
		.clock     (clock),
		.nrst      (nrst),
		.seq_we    (seq_res.vis_we),
		.seq_data  (seq_res.vis_data[15:8]),
		.host_we   (wr_vis_high),
		.host_data (host_req.wdata),
		.value     (vis_high)
	);

	// Infrared word, low byte
	result_byte u_ir_low (
		.clock     (clock),
		.nrst      (nrst),
		.seq_we    (seq_res.ir_we),
		.seq_data  (seq_res.ir_low),
		.host_we   (wr_ir_low),
		.host_data (host_req.wdata),
		.value     (ir_low)
	);

	// Read mux; unmapped addresses read zero
	// Reads have no side effect; flags clear only on an explicit write or, in mode 1, a sequencer clear
	logic [7:0] rd_mux;

	assign rd_mux = sel_response ? response_r :
			sel_status   ? status_w   :
			sel_vis_low  ? vis_low    :
			sel_vis_high ? vis_high   :
			sel_ir_low   ? ir_low     : 8'h00;

	// Read data is captured on the read strobe and held until the next read
	// Unread data stays put, so a slow host still sees a steady byte
	logic [7:0] rdata_r;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= 8'h00;
		end else if (host_req.rd) begin
			rdata_r <= rd_mux;
		end
	end

	assign host_rdata = rdata_r;

endmodule

// >>> design/sensor_flags_pkg.sv
/*
 * Constants and carrier types for the event-flag and result slice.
 * Assumes one device clock and that every module imports the whole package.
 */
// Contract
// - Overflow loads response 0x8A, 0x8D or 0x8E
// - Command completion sets status bit five
// - Proximity flags three, two, one in bits 4:2
// - Ambient field bits 1:0, bits 7:6 reserved
// - Interrupt when any flag and enable set
// - Mode 0: flag holds until host writes one
// - Mode 1: sequencer clears, except condition 11
// - Status, visible high, infrared low reset zero
// - Visible word low 0x22, high 0x23
// - Infrared low byte at 0x24
// - Every error code has top bit set
// - Error held, commands ignored until reset or nop
package sensor_flags_pkg;

	// Register offsets on the serial register port
	localparam logic [7:0] response_off    = 8'h20;
	localparam logic [7:0] status_off      = 8'h21;
	localparam logic [7:0] vis_low_off     = 8'h22;
	localparam logic [7:0] vis_high_off    = 8'h23;
	localparam logic [7:0] ir_low_off      = 8'h24;

	// Status field positions
	localparam int         cmd_bit         = 5;
	localparam int         prox_three_bit  = 4;
	localparam int         prox_two_bit    = 3;
	localparam int         prox_one_bit    = 2;
	localparam int         amb_lsb         = 0;
	localparam int         amb_width       = 2;
	localparam logic [7:0] status_wmask    = 8'h3f;

	// Reset values
	localparam logic [7:0] status_rst      = 8'h00;
	localparam logic [7:0] result_rst      = 8'h00;
	localparam logic [7:0] response_rst    = 8'h00;

	// Response codes
	localparam logic [7:0] err_ovf_prox3   = 8'h8a;
	localparam logic [7:0] err_ovf_vis     = 8'h8d;
	localparam logic [7:0] err_ovf_aux     = 8'h8e;
	localparam int         err_flag_bit    = 7;
	localparam logic [1:0] cond_no_autoclr = 2'h3;

	// Host access on the register port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Events raised by the measurement sequencer
	typedef struct packed {
		logic       cmd_done;
		logic [2:0] prox_set;
		logic [1:0] amb_set;
		logic       auto_clear;
	} seq_event_t;

	// Results loaded by the sequencer
	typedef struct packed {
		logic        vis_we;
		logic [15:0] vis_data;
		logic        ir_we;
		logic [7:0]  ir_low;
	} result_wr_t;

	// Converter overflow reports
	typedef struct packed {
		logic prox3;
		logic vis;
		logic aux;
	} overflow_t;

endpackage

// >>> design/sticky_flag.sv
/*
 * Sticky event flag of parameterised width with host write-one-to-clear
 * and a sequencer clear. Assumes set and clear pulses are clock synchronous.
 */
`timescale 1ns/1ps
module sticky_flag
	import sensor_flags_pkg::*;
#(
	parameter int w = 1
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic [w-1:0] set_val,
	input  wire logic [w-1:0] host_clr,
	input  wire logic         seq_clr,
	output logic      [w-1:0] flag
);

	logic [w-1:0] flag_r;
	logic [w-1:0] flag_nxt;

	// New events win over any clear in the same cycle
	assign flag_nxt = (set_val != '0) ? set_val : (flag_r & ~host_clr & ~{w{seq_clr}});
	assign flag     = flag_r;

	// Zero is the idle state after reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			flag_r <= '0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

endmodule

// >>> design/result_byte.sv
/*
 * One result byte: loaded by the sequencer, writable by the host.
 * Assumes the sequencer load and host write may coincide.
 */
`timescale 1ns/1ps
module result_byte
	import sensor_flags_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic       seq_we,
	input  wire logic [7:0] seq_data,
	input  wire logic       host_we,
	input  wire logic [7:0] host_data,
	output logic      [7:0] value
);

	logic [7:0] value_r;

	// Fresh measurement takes priority over a host write
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			value_r <= result_rst;
		end else if (seq_we) begin
			value_r <= seq_data;
		end else if (host_we) begin
			value_r <= host_data;
		end
	end

	assign value = value_r;

endmodule

// >>> verification/sensor_flags_checker.sv
/*
 * Port assertions for the flag, response and result block.
 * Assumes one clock domain; bound to every instance of the block.
 */
`timescale 1ns/1ps
module sensor_flags_checker
	import sensor_flags_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire reg_req_t   host_req,
	input  wire seq_event_t seq_evt,
	input  wire overflow_t  adc_ovf,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_is_clear,
	input  wire logic       cmd_accept,
	input  wire logic       int_mode,
	input  wire logic [5:0] irq_enable,
	input  wire logic       int_out,
	input  wire logic [7:0] response,
	input  wire logic [7:0] status
);
	// Enabled pending events; enable bit 0 gates any nonzero ambient code
	wire pend = |(status[5:2] & irq_enable[5:2]) | (|status[1:0] & irq_enable[0]);
	wire err  = response[7];
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Host clears the command flag while nothing sets it again
	sequence s_w1c; host_req.wr && host_req.addr == 8'h21 && host_req.wdata[5]; endsequence
	sequence s_quiet; !seq_evt.cmd_done; endsequence
	property p_w1c; s_w1c ##0 s_quiet |=> !status[5]; endproperty
	property p_hold; status[5] && !int_mode && !host_req.wr |=> status[5]; endproperty
	property p_ovf3; !err && adc_ovf.prox3 |=> response == 8'h8a; endproperty
	property p_ovfv; !err && !adc_ovf.prox3 && adc_ovf.vis |=> response == 8'h8d; endproperty
	property p_ovfa; !err && adc_ovf == 3'b001 |=> response == 8'h8e; endproperty
	property p_msb; $rose(err) |-> response inside {8'h8a, 8'h8d, 8'h8e}; endproperty
	property p_keep; err && !(cmd_valid && cmd_is_clear) |=> response == $past(response); endproperty
	property p_acc; cmd_accept == (cmd_valid && (!err || cmd_is_clear)); endproperty
	property p_cmd; seq_evt.cmd_done |=> status[5]; endproperty
	property p_prox; seq_evt.prox_set[2] |=> status[4]; endproperty
	property p_rsv; status[7:6] == 2'b00; endproperty
	property p_int; 1 |=> int_out == $past(pend); endproperty
	property p_auto; int_mode && seq_evt.auto_clear && !seq_evt.cmd_done |=> !status[5]; endproperty
	a_w1c: assert property (p_w1c) else $error("command flag not cleared");
	a_hold: assert property (p_hold) else $error("command flag dropped");
	a_ovf3: assert property (p_ovf3) else $error("bad overflow code three");
	a_ovfv: assert property (p_ovfv) else $error("bad overflow code visible");
	a_ovfa: assert property (p_ovfa) else $error("bad overflow code aux");
	a_msb: assert property (p_msb) else $error("error code out of set");
	a_keep: assert property (p_keep) else $error("error code not kept");
	a_acc: assert property (p_acc) else $error("wrong command accept");
	a_cmd: assert property (p_cmd) else $error("command flag not set");
	a_prox: assert property (p_prox) else $error("proximity three flag not set");
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	a_int: assert property (p_int) else $error("interrupt output wrong");
	a_auto: assert property (p_auto) else $error("auto clear missed");
endmodule

bind sensor_event_flags_and_results sensor_flags_checker i_chk (.clock, .nrst, .host_req, .seq_evt,
	.adc_ovf, .cmd_valid, .cmd_is_clear, .cmd_accept, .int_mode, .irq_enable, .int_out, .response, .status);

// >>> verification/host_model.sv
/*
 * Host side of the register port: one access at a time.
 * Assumes read data is ready half a cycle after the taking edge.
 */
`timescale 1ns/1ps
module host_model
	import sensor_flags_pkg::*;
(
	input  wire logic       clock,
	input  wire logic [7:0] host_rdata,
	output reg_req_t        host_req
);
	initial host_req = '0;
	// Request held to its taking edge; idle cycle avoids double takes
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clock);
		host_req <= '0;
		@(negedge clock);
		q = host_rdata;
		@(posedge clock);
	endtask
endmodule

// >>> verification/test_sensor_event_flags_and_results.sv
/*
 * Self-checking bench with a reference model of flags, response and results.
 * Assumes the host model drives the register port; the bench drives the rest.
 */
`timescale 1ns/1ps
module test_sensor_event_flags_and_results
	import sensor_flags_pkg::*;
;
	logic             clock = 0;
	logic             nrst = 0;
	reg_req_t         host_req;
	logic       [7:0] host_rdata, response, status, q, a, d;
	seq_event_t       seq_evt = '0;
	result_wr_t       seq_res = '0;
	overflow_t        adc_ovf = '0;
	logic             cmd_valid = 0, cmd_is_clear = 0, int_mode = 0, cmd_accept, int_out;
	logic       [5:0] irq_enable = '0;
	logic [2:0] [1:0] cond = '0;
	int               n_mismatch, checks, cyc, m_st, m_resp, m_vis, m_ir;

	always #2.5 clock = ~clock;

	sensor_event_flags_and_results i_sensor_event_flags_and_results (.clock, .nrst, .host_req, .host_rdata,
		.seq_evt, .seq_res, .adc_ovf, .cmd_valid, .cmd_is_clear, .cmd_accept, .int_mode, .irq_enable,
		.proximity_event_condition_one(cond[0]), .proximity_event_condition_two(cond[1]),
		.proximity_event_condition_three(cond[2]), .int_out, .response, .status);
	host_model i_host_model (.clock, .host_rdata, .host_req);

	// Compare and count
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task end_sim;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Model views of the register map and the interrupt
	function automatic logic [7:0] mreg(input logic [7:0] x);
		case (x)
			8'h20: return m_resp[7:0];
			8'h21: return m_st[7:0];
			8'h22: return m_vis[7:0];
			8'h23: return m_vis[15:8];
			8'h24: return m_ir[7:0];
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic pend();
		return |(m_st[5:2] & irq_enable[5:2]) || (m_st[1:0] != 0 && irq_enable[0]);
	endfunction

	// One random sequencer cycle, then model update and checks
	task automatic step;
		seq_event_t e;
		result_wr_t r;
		overflow_t  o;
		logic       cv, cc;
		e = 7'($urandom);
		r = 26'($urandom);
		o = ($urandom % 4 == 0) ? 3'($urandom) : 3'd0;
		cv = 1'($urandom);
		cc = 1'($urandom);
		if (cv && cc)
			e.cmd_done = 0;
		seq_evt <= e;
		seq_res <= r;
		adc_ovf <= o;
		cmd_valid <= cv;
		cmd_is_clear <= cc;
		int_mode <= 1'($urandom);
		irq_enable <= 6'($urandom);
		cond <= 6'($urandom);
		#1 chk("accept", {7'h0, cmd_accept}, {7'h0, cv && (!m_resp[7] || cc)});
		@(posedge clock);
		seq_evt <= '0;
		seq_res <= '0;
		adc_ovf <= '0;
		cmd_valid <= 0;
		if (int_mode && e.auto_clear)
			m_st = m_st & {3'b000, cond[2] == 2'h3, cond[1] == 2'h3, cond[0] == 2'h3, 2'b00};
		m_st = m_st | {e.cmd_done, e.prox_set, 2'b00};
		if (e.amb_set != 0)
			m_st[1:0] = e.amb_set;
		if (!m_resp[7] && o != 0)
			m_resp = o.prox3 ? 8'h8a : o.vis ? 8'h8d : 8'h8e;
		else if (cv && cc)
			m_resp = 0;
		else if (!m_resp[7] && e.cmd_done)
			m_resp = (m_resp + 1) % 16;
		if (r.vis_we)
			m_vis = r.vis_data;
		if (r.ir_we)
			m_ir = r.ir_low;
		@(negedge clock);
		chk("status", status, m_st[7:0]);
		chk("response", response, m_resp[7:0]);
		@(posedge clock);
		@(negedge clock);
		chk("int_out", {7'h0, int_out}, {7'h0, pend()});
		@(posedge clock);
	endtask

	// Hang guard: far beyond the expected run length
	always @(posedge clock) begin
		cyc++;
		if (cyc > 10000) begin
			n_mismatch++;
			end_sim();
		end
	end

	// Reset reads, then random events mixed with host accesses
	initial begin
		void'($urandom(21742));
		repeat (2) @(posedge clock);
		nrst <= 1;
		@(posedge clock);
		for (int i = 32; i < 38; i++) begin
			i_host_model.acc(1'b0, 8'(i), 8'h00, q);
			chk("reset read", q, 8'h00);
		end
		for (int i = 0; i < 300; i++) begin
			step();
			a = 8'h20 + 8'($urandom % 6);
			d = 8'($urandom);
			if ($urandom % 2) begin
				i_host_model.acc(1'b1, a, d, q);
				case (a)
					8'h21: m_st = m_st & ~(d & 8'h3f);
					8'h22: m_vis[7:0] = d;
					8'h23: m_vis[15:8] = d;
					8'h24: m_ir = d;
					default: ;
				endcase
			end else begin
				i_host_model.acc(1'b0, a, 8'h00, q);
				chk("read", q, mreg(a));
			end
		end
		// Mid-run reset must wipe what the random phase left behind
		nrst <= 0;
		repeat (2) @(posedge clock);
		chk("reset status", status, 8'h00);
		chk("reset response", response, 8'h00);
		chk("reset int_out", {7'h0, int_out}, 8'h00);
		chk("reset rdata", host_rdata, 8'h00);
		nrst <= 1;
		@(posedge clock);
		for (int i = 32; i < 38; i++) begin
			i_host_model.acc(1'b0, 8'(i), 8'h00, q);
			chk("rerun read", q, 8'h00);
		end
		end_sim();
	end
endmodule
